// ---- inc/imprc_defs.svh ----
`ifndef IMPRC_DEFS_SVH
`define IMPRC_DEFS_SVH

`define IMPRC_DATA_W        32
`define IMPRC_ADDR_W        12
`define IMPRC_ID_W          5

`define IMPRC_OFF_NVEC      12'h100
`define IMPRC_OFF_FVEC      12'h104
`define IMPRC_OFF_CURID     12'h108
`define IMPRC_OFF_PEND      12'h10c
`define IMPRC_OFF_MASK      12'h110
`define IMPRC_OFF_CORE      12'h114
`define IMPRC_OFF_ENABLE    12'h120
`define IMPRC_OFF_DISABLE   12'h124
`define IMPRC_OFF_CLEAR     12'h128
`define IMPRC_OFF_SET       12'h12c
`define IMPRC_OFF_EOS       12'h130
`define IMPRC_OFF_SPU       12'h134
`define IMPRC_OFF_DEBUG     12'h138
`define IMPRC_OFF_FFEN      12'h140
`define IMPRC_OFF_FFDIS     12'h144
`define IMPRC_OFF_FFSTAT    12'h148
`define IMPRC_OFF_EVSTAT    12'h150
`define IMPRC_OFF_EVCLR     12'h154
`define IMPRC_OFF_EVEN      12'h158

`define IMPRC_RST_WORD      32'h0000_0000
`define IMPRC_RST_DEBUG     2'h0
`define IMPRC_RST_EV        3'h0

`define IMPRC_BIT_FAST      0
`define IMPRC_BIT_SYS       1
`define IMPRC_BIT_PROTECTION_MODE_BIT      0
`define IMPRC_BIT_GLOBAL_LINE_MASK_BIT      1
`define IMPRC_DEBUG_W       2

`define IMPRC_EV_W          3
`define IMPRC_EV_SPUR_NORM  0
`define IMPRC_EV_SPUR_FAST  1
`define IMPRC_EV_EOS_IDLE   2

`endif

// ---- inc/imprc_pkg.sv ----
`default_nettype none
`include "imprc_defs.svh"
package imprc_pkg;

  typedef struct packed {
    logic [`IMPRC_ADDR_W-1:0] addr;
    logic [`IMPRC_DATA_W-1:0] wdata;
    logic                     wr;
    logic                     rd;
  } imprc_bus_req_t;

  typedef enum logic {
    SVC_IDLE,
    SVC_BUSY
  } imprc_svc_t;

endpackage
`default_nettype wire

// ---- src/imprc_top.sv ----
// Strobed register access and the address map are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "imprc_defs.svh"
module imprc_top #(
  parameter int NUM_SRC = 32
) (
  input  wire logic                       clock,
  input  wire logic                       rst_b,
  input  wire imprc_pkg::imprc_bus_req_t  busReq,
  output logic [`IMPRC_DATA_W-1:0]        busRdata,
  input  wire logic [NUM_SRC-1:0]         sourceRequest,
  input  wire logic [`IMPRC_DATA_W-1:0]   candidateVector,
  input  wire logic [`IMPRC_DATA_W-1:0]   fastVector,
  output logic [`IMPRC_ID_W-1:0]          candidateId,
  output logic                            coreNormalRequestLine_n,
  output logic                            coreFastRequestLine_n,
  output logic                            irq
);
  import imprc_pkg::*;

  // wider source sets would not fit one readable word
  if (NUM_SRC < 2 || NUM_SRC > `IMPRC_DATA_W) begin : gBadWidth
    $error("NUM_SRC must lie between 2 and the data width");
  end

  function automatic logic hit(input logic [`IMPRC_ADDR_W-1:0] a,
                               input logic [`IMPRC_ADDR_W-1:0] off);
    hit = (a == off);
  endfunction

  function automatic logic [`IMPRC_ID_W-1:0] lowestSet(input logic [NUM_SRC-1:0] v);
    logic [`IMPRC_ID_W-1:0] idx;
    idx = '0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        idx = `IMPRC_ID_W'(i);
      end
    end
    lowestSet = idx;
  endfunction

  // state
  logic [NUM_SRC-1:0]        pendQ, pendD;
  logic [NUM_SRC-1:0]        maskQ, maskD;
  logic [NUM_SRC-1:0]        forceQ, forceD;
  logic [NUM_SRC-1:0]        srcPrevQ;
  logic [`IMPRC_DATA_W-1:0]  spuQ;
  logic [`IMPRC_DEBUG_W-1:0] debugQ;
  logic                      fastActiveQ, normalActiveQ;
  logic [`IMPRC_ID_W-1:0]    candIdQ, curIdQ;
  logic                      candValidQ;
  imprc_svc_t                svcQ, svcD;
  logic [`IMPRC_EV_W-1:0]    evQ, evEnQ, evSet;
  logic [`IMPRC_DATA_W-1:0]  rdataQ, rdataD;

  // address decode
  wire logic wrEnable  = busReq.wr && hit(busReq.addr, `IMPRC_OFF_ENABLE);
  wire logic wrDisable = busReq.wr && hit(busReq.addr, `IMPRC_OFF_DISABLE);
  wire logic wrClear   = busReq.wr && hit(busReq.addr, `IMPRC_OFF_CLEAR);
  wire logic wrSet     = busReq.wr && hit(busReq.addr, `IMPRC_OFF_SET);
  wire logic wrEos     = busReq.wr && hit(busReq.addr, `IMPRC_OFF_EOS);
  wire logic wrSpu     = busReq.wr && hit(busReq.addr, `IMPRC_OFF_SPU);
  wire logic wrDebug   = busReq.wr && hit(busReq.addr, `IMPRC_OFF_DEBUG);
  wire logic wrFfEn    = busReq.wr && hit(busReq.addr, `IMPRC_OFF_FFEN);
  wire logic wrFfDis   = busReq.wr && hit(busReq.addr, `IMPRC_OFF_FFDIS);
  wire logic wrEvClr   = busReq.wr && hit(busReq.addr, `IMPRC_OFF_EVCLR);
  wire logic wrEvEn    = busReq.wr && hit(busReq.addr, `IMPRC_OFF_EVEN);
  wire logic wrNvec    = busReq.wr && hit(busReq.addr, `IMPRC_OFF_NVEC);
  wire logic rdNvec    = busReq.rd && hit(busReq.addr, `IMPRC_OFF_NVEC);
  wire logic rdFvec    = busReq.rd && hit(busReq.addr, `IMPRC_OFF_FVEC);

  wire logic [NUM_SRC-1:0] wBits   = busReq.wdata[NUM_SRC-1:0];
  wire logic               protOn  = debugQ[`IMPRC_BIT_PROTECTION_MODE_BIT];
  wire logic               gmskOn  = debugQ[`IMPRC_BIT_GLOBAL_LINE_MASK_BIT];

  // forcing never applies to the fast source itself
  localparam logic [NUM_SRC-1:0] FORCE_IMPL = ~NUM_SRC'(1);

  wire logic [NUM_SRC-1:0] srcRise   = sourceRequest & ~srcPrevQ;
  wire logic [NUM_SRC-1:0] enabled   = pendQ & maskQ;
  wire logic [NUM_SRC-1:0] fastRoute = forceQ | NUM_SRC'(1);
  wire logic [NUM_SRC-1:0] normCand  = enabled & ~fastRoute;
  wire logic               fastReq   = |(enabled & fastRoute);
  wire logic               normReq   = |normCand && (svcQ == SVC_IDLE);

  // acknowledge: vector read when protection is off; when it is on, normal vector write only, fast never
  wire logic nAck      = (protOn ? wrNvec : rdNvec) && candValidQ && (svcQ == SVC_IDLE);
  wire logic nSpurious = rdNvec && !(candValidQ && (svcQ == SVC_IDLE));
  wire logic fAck      = rdFvec && fastReq && !protOn;
  wire logic fSpurious = rdFvec && !fastReq;

  // pending: edges and set win over any clear in the same cycle
  logic [NUM_SRC-1:0] ackClr;
  always_comb begin
    ackClr = '0;
    if (nAck) begin
      ackClr[candIdQ] = 1'b1;
    end
    if (fAck) begin
      ackClr[`IMPRC_BIT_FAST] = 1'b1;
    end
  end

  assign pendD = (pendQ & ~(wrClear ? wBits : '0) & ~ackClr)
               | (wrSet ? wBits : '0)
               | srcRise;
  assign maskD = (maskQ | (wrEnable ? wBits : '0))
               & ~(wrDisable ? wBits : '0);
  assign forceD = ((forceQ | (wrFfEn ? wBits : '0))
                & ~(wrFfDis ? wBits : '0)) & FORCE_IMPL;

  // one service at a time; nesting needs the priority stage
  always_comb begin
    svcD = svcQ;
    case (svcQ)
      SVC_IDLE: begin
        if (nAck) begin
          svcD = SVC_BUSY;
        end
      end
      SVC_BUSY: begin
        if (wrEos) begin
          svcD = SVC_IDLE;
        end
      end
      default: svcD = SVC_IDLE;
    endcase
  end

  assign evSet = {wrEos && (svcQ == SVC_IDLE), fSpurious, nSpurious};

  // read mux
  always_comb begin
    rdataD = '0;
    if (busReq.rd) begin
      case (busReq.addr)
        `IMPRC_OFF_NVEC:   rdataD = nSpurious ? spuQ : candidateVector;
        `IMPRC_OFF_FVEC:   rdataD = fastReq ? fastVector : spuQ;
        `IMPRC_OFF_CURID:  rdataD = `IMPRC_DATA_W'(curIdQ);
        `IMPRC_OFF_PEND:   rdataD = `IMPRC_DATA_W'(pendQ);
        `IMPRC_OFF_MASK:   rdataD = `IMPRC_DATA_W'(maskQ);
        `IMPRC_OFF_CORE:   rdataD = `IMPRC_DATA_W'({normalActiveQ, fastActiveQ});
        `IMPRC_OFF_SPU:    rdataD = spuQ;
        `IMPRC_OFF_DEBUG:  rdataD = `IMPRC_DATA_W'(debugQ);
        `IMPRC_OFF_FFSTAT: rdataD = `IMPRC_DATA_W'(forceQ);
        `IMPRC_OFF_EVSTAT: rdataD = `IMPRC_DATA_W'(evQ);
        `IMPRC_OFF_EVEN:   rdataD = `IMPRC_DATA_W'(evEnQ);
        default:           rdataD = '0;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pendQ    <= '0;
      maskQ    <= '0;
      forceQ   <= '0;
      srcPrevQ <= '0;
    end else begin
      pendQ    <= pendD;
      maskQ    <= maskD;
      forceQ   <= forceD;
      srcPrevQ <= sourceRequest;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      spuQ   <= `IMPRC_RST_WORD;
      debugQ <= `IMPRC_RST_DEBUG;
    end else begin
      if (wrSpu) begin
        spuQ <= busReq.wdata;
      end
      if (wrDebug) begin
        debugQ <= busReq.wdata[`IMPRC_DEBUG_W-1:0];
      end
    end
  end

  // lines are registered so they never glitch toward the core
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      fastActiveQ   <= 1'b0;
      normalActiveQ <= 1'b0;
    end else begin
      fastActiveQ   <= fastReq && !gmskOn;
      normalActiveQ <= normReq && !gmskOn;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      candIdQ    <= '0;
      candValidQ <= 1'b0;
      curIdQ     <= '0;
      svcQ       <= SVC_IDLE;
    end else begin
      candIdQ    <= lowestSet(normCand);
      candValidQ <= |normCand;
      svcQ       <= svcD;
      if (nAck) begin
        curIdQ <= candIdQ;
      end
    end
  end

  // set wins over a clear in the same cycle
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      evQ    <= `IMPRC_RST_EV;
      evEnQ  <= `IMPRC_RST_EV;
      rdataQ <= '0;
    end else begin
      evQ    <= (evQ & ~(wrEvClr ? busReq.wdata[`IMPRC_EV_W-1:0] : '0)) | evSet;
      rdataQ <= rdataD;
      if (wrEvEn) begin
        evEnQ <= busReq.wdata[`IMPRC_EV_W-1:0];
      end
    end
  end

  assign busRdata                = rdataQ;
  assign candidateId             = candIdQ;
  assign coreFastRequestLine_n   = !fastActiveQ;
  assign coreNormalRequestLine_n = !normalActiveQ;
  assign irq                     = |(evQ & evEnQ);

  property p_enable;
    @(posedge clock) disable iff (!rst_b)
    wrEnable |=> ((maskQ & $past(wBits)) == $past(wBits));
  endproperty
  a_enable: assert property (p_enable) else $error("enable did not set mask");

  property p_disable;
    @(posedge clock) disable iff (!rst_b)
    wrDisable |=> ((maskQ & $past(wBits)) == '0);
  endproperty
  a_disable: assert property (p_disable) else $error("disable did not clear mask");

  property p_clear;
    @(posedge clock) disable iff (!rst_b)
    wrClear && (srcRise == '0) |=> ((pendQ & $past(wBits)) == '0);
  endproperty
  a_clear: assert property (p_clear) else $error("clear left pending bits");

  property p_set;
    @(posedge clock) disable iff (!rst_b)
    wrSet |=> ((pendQ & $past(wBits)) == $past(wBits));
  endproperty
  a_set: assert property (p_set) else $error("set did not raise pending");

  property p_global_line_mask_bit;
    @(posedge clock) disable iff (!rst_b)
    gmskOn |=> (coreNormalRequestLine_n && coreFastRequestLine_n);
  endproperty
  a_global_line_mask_bit: assert property (p_global_line_mask_bit) else $error("line active under general mask");

  property p_ffen;
    @(posedge clock) disable iff (!rst_b)
    wrFfEn |=> !forceQ[`IMPRC_BIT_FAST] && ((forceQ & $past(wBits) & FORCE_IMPL)
                                           == ($past(wBits) & FORCE_IMPL));
  endproperty
  a_ffen: assert property (p_ffen) else $error("forcing enable wrong");

  property p_spur;
    @(posedge clock) disable iff (!rst_b)
    nSpurious |=> (busRdata == $past(spuQ));
  endproperty
  a_spur: assert property (p_spur) else $error("spurious read missed vector");

  property p_cmdzero;
    @(posedge clock) disable iff (!rst_b)
    busReq.rd && hit(busReq.addr, `IMPRC_OFF_ENABLE) |=> (busRdata == '0);
  endproperty
  a_cmdzero: assert property (p_cmdzero) else $error("command read not zero");

  property p_core;
    @(posedge clock) disable iff (!rst_b)
    busReq.rd && hit(busReq.addr, `IMPRC_OFF_CORE) |=>
      (busRdata[1:0] == {!$past(coreNormalRequestLine_n), !$past(coreFastRequestLine_n)});
  endproperty
  a_core: assert property (p_core) else $error("core status mismatch");

  property p_eos;
    @(posedge clock) disable iff (!rst_b)
    wrEos |=> (svcQ == SVC_IDLE) ##1
      (coreNormalRequestLine_n == !$past(|normCand && !gmskOn));
  endproperty
  a_eos: assert property (p_eos) else $error("service not ended by end write");

  property p_pendEdge;
    @(posedge clock) disable iff (!rst_b)
    (srcRise != '0) |=> ((pendQ & $past(srcRise)) == $past(srcRise));
  endproperty
  a_pendEdge: assert property (p_pendEdge) else $error("source edge not pending");

  property p_pendRead;
    @(posedge clock) disable iff (!rst_b)
    busReq.rd && hit(busReq.addr, `IMPRC_OFF_PEND) |=>
      (busRdata == `IMPRC_DATA_W'($past(pendQ)));
  endproperty
  a_pendRead: assert property (p_pendRead) else $error("pending view mismatch");

  property p_maskRead;
    @(posedge clock) disable iff (!rst_b)
    busReq.rd && hit(busReq.addr, `IMPRC_OFF_MASK) |=>
      (busRdata == `IMPRC_DATA_W'($past(maskQ)));
  endproperty
  a_maskRead: assert property (p_maskRead) else $error("mask view mismatch");

  property p_enableKeep;
    @(posedge clock) disable iff (!rst_b)
    wrEnable |=> ((maskQ & ~$past(wBits)) == ($past(maskQ) & ~$past(wBits)));
  endproperty
  a_enableKeep: assert property (p_enableKeep) else $error("enable zero bit moved mask");

  property p_disableKeep;
    @(posedge clock) disable iff (!rst_b)
    wrDisable |=> ((maskQ & ~$past(wBits)) == ($past(maskQ) & ~$past(wBits)));
  endproperty
  a_disableKeep: assert property (p_disableKeep) else $error("disable zero bit moved mask");

  property p_fastLine;
    @(posedge clock) disable iff (!rst_b)
    fastReq && !gmskOn |=> !coreFastRequestLine_n;
  endproperty
  a_fastLine: assert property (p_fastLine) else $error("fast line not driven");

  property p_normLine;
    @(posedge clock) disable iff (!rst_b)
    normReq && !gmskOn |=> !coreNormalRequestLine_n;
  endproperty
  a_normLine: assert property (p_normLine) else $error("normal line not driven");

  property p_svcBusy;
    @(posedge clock) disable iff (!rst_b)
    nAck |=> (svcQ == SVC_BUSY);
  endproperty
  a_svcBusy: assert property (p_svcBusy) else $error("acknowledge did not start service");

  property p_spuWrite;
    @(posedge clock) disable iff (!rst_b)
    wrSpu |=> (spuQ == $past(busReq.wdata));
  endproperty
  a_spuWrite: assert property (p_spuWrite) else $error("spurious vector not stored");

  property p_fvecSpur;
    @(posedge clock) disable iff (!rst_b)
    fSpurious |=> (busRdata == $past(spuQ));
  endproperty
  a_fvecSpur: assert property (p_fvecSpur) else $error("fast spurious read missed vector");

  property p_debugWrite;
    @(posedge clock) disable iff (!rst_b)
    wrDebug |=> (debugQ == $past(busReq.wdata[`IMPRC_DEBUG_W-1:0]));
  endproperty
  a_debugWrite: assert property (p_debugWrite) else $error("debug control not stored");

  property p_ffdis;
    @(posedge clock) disable iff (!rst_b)
    wrFfDis |=> ((forceQ & $past(wBits)) == '0);
  endproperty
  a_ffdis: assert property (p_ffdis) else $error("forcing disable left bits");

  property p_ffstat;
    @(posedge clock) disable iff (!rst_b)
    busReq.rd && hit(busReq.addr, `IMPRC_OFF_FFSTAT) |=>
      !busRdata[`IMPRC_BIT_FAST];
  endproperty
  a_ffstat: assert property (p_ffstat) else $error("forcing status shows fast source");

  property p_rdIdle;
    @(posedge clock) disable iff (!rst_b)
    !busReq.rd |=> (busRdata == '0);
  endproperty
  a_rdIdle: assert property (p_rdIdle) else $error("read data outside read slot");

endmodule
`default_nettype wire

// ---- verification/imprc_core_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module imprc_core_model (
  input  wire logic clock,
  input  wire logic rst_b,
  input  wire logic normalLine_n,
  input  wire logic fastLine_n,
  output logic      normalActive,
  output logic      fastActive
);
  // core samples its lines once a clock, so a one-cycle dip is still seen
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      normalActive <= 1'b0;
      fastActive   <= 1'b0;
    end else begin
      normalActive <= !normalLine_n;
      fastActive   <= !fastLine_n;
    end
  end
endmodule
`default_nettype wire

// ---- verification/testbench.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "imprc_defs.svh"
module testbench;
  import imprc_pkg::*;
  logic           clock;
  logic           rst_b;
  imprc_bus_req_t busReq;
  logic [31:0]    busRdata;
  logic [31:0]    sourceRequest;
  logic [31:0]    candidateVector;
  logic [31:0]    fastVector;
  logic [4:0]     candidateId;
  logic           lineN_n;
  logic           lineF_n;
  logic           irq;
  logic           normalActive;
  logic           fastActive;
  logic [31:0]    r;
  logic [31:0]    v;
  logic [31:0]    st;
  int             n_errors;
  int             cmp_count;
  int             seed;
  logic [11:0]    zeroA[14] = '{`IMPRC_OFF_PEND, `IMPRC_OFF_MASK, `IMPRC_OFF_CORE,
    `IMPRC_OFF_SPU, `IMPRC_OFF_DEBUG, `IMPRC_OFF_FFSTAT, `IMPRC_OFF_ENABLE,
    `IMPRC_OFF_DISABLE, `IMPRC_OFF_CLEAR, `IMPRC_OFF_SET, `IMPRC_OFF_EOS,
    `IMPRC_OFF_FFEN, `IMPRC_OFF_FFDIS, 12'h118};
  logic [11:0]    setA[3] = '{`IMPRC_OFF_ENABLE, `IMPRC_OFF_SET, `IMPRC_OFF_FFEN};
  logic [11:0]    clrA[3] = '{`IMPRC_OFF_DISABLE, `IMPRC_OFF_CLEAR, `IMPRC_OFF_FFDIS};
  logic [11:0]    viewA[3] = '{`IMPRC_OFF_MASK, `IMPRC_OFF_PEND, `IMPRC_OFF_FFSTAT};

  imprc_top #(.NUM_SRC(32)) i_dut (
    .clock(clock), .rst_b(rst_b), .busReq(busReq), .busRdata(busRdata),
    .sourceRequest(sourceRequest), .candidateVector(candidateVector),
    .fastVector(fastVector), .candidateId(candidateId),
    .coreNormalRequestLine_n(lineN_n), .coreFastRequestLine_n(lineF_n), .irq(irq));

  imprc_core_model i_model (
    .clock(clock), .rst_b(rst_b), .normalLine_n(lineN_n), .fastLine_n(lineF_n),
    .normalActive(normalActive), .fastActive(fastActive));

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  function automatic logic [31:0] upd(input logic [31:0] o, input logic [31:0] d,
                                      input logic s);
    return s ? (o | d) : (o & ~d);
  endfunction

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, s, e);
    end
  endtask

  // one access per call; slave never stalls, data read at the edge closing its cycle
  task automatic acc(input logic [11:0] a, input logic [31:0] d, input logic w);
    busReq <= '{a, d, w, !w};
    @(posedge clock);
    busReq <= '{a, d, 1'b0, 1'b0};
    @(posedge clock);
    r = busRdata;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    acc(a, d, 1'b1);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    acc(a, 32'h0, 1'b0);
    chk(r, e);
  endtask

  task complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    #(50 * 20000);
    n_errors++;
    complete_run;
  end

  initial begin
    seed = 11013;
    rst_b = 1'b0;
    busReq = '0;
    sourceRequest = '0;
    candidateVector = $random(seed);
    fastVector = $random(seed);
    n_errors = 0;
    cmp_count = 0;
    repeat (10) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    foreach (zeroA[i]) rdc(zeroA[i], 32'h0);
    $display("test 1 done: reset and write-only reads");
    // mask, pending and forcing views, sources held low so no line moves
    for (int k = 0; k < 3; k++) begin
      st = '0;
      for (int i = 0; i < 30; i++) begin
        v = $random(seed);
        wr(i[0] ? setA[k] : clrA[k], v);
        st = upd(st, v, i[0]) & ((k == 2) ? 32'hffff_fffe : 32'hffff_ffff);
        rdc(viewA[k], st);
      end
      wr(clrA[k], 32'hffff_ffff);
    end
    $display("test 2 done: command registers");
    v = $random(seed);
    wr(`IMPRC_OFF_SPU, v);
    rdc(`IMPRC_OFF_SPU, v);
    wr(`IMPRC_OFF_EVEN, 32'h1);
    rdc(`IMPRC_OFF_NVEC, v);
    chk({31'h0, irq}, 32'h1);
    rdc(`IMPRC_OFF_FVEC, v);
    rdc(`IMPRC_OFF_EVSTAT, 32'h3);
    wr(`IMPRC_OFF_EVEN, 32'h0);
    chk({31'h0, irq}, 32'h0);
    wr(`IMPRC_OFF_EVCLR, 32'h7);
    rdc(`IMPRC_OFF_EVSTAT, 32'h0);
    $display("test 3 done: spurious vector and events");
    wr(`IMPRC_OFF_DEBUG, 32'h1);
    rdc(`IMPRC_OFF_DEBUG, 32'h1);
    wr(`IMPRC_OFF_DEBUG, 32'h0);
    wr(`IMPRC_OFF_ENABLE, 32'h21);
    sourceRequest <= 32'h20;
    repeat (4) @(posedge clock);
    chk({27'h0, candidateId}, 32'h5);
    chk({30'h0, fastActive, normalActive}, 32'h1);
    rdc(`IMPRC_OFF_CORE, 32'h2);
    wr(`IMPRC_OFF_DEBUG, 32'h2);
    repeat (2) @(posedge clock);
    chk({30'h0, fastActive, normalActive}, 32'h0);
    rdc(`IMPRC_OFF_CORE, 32'h0);
    wr(`IMPRC_OFF_DEBUG, 32'h0);
    rdc(`IMPRC_OFF_NVEC, candidateVector);
    rdc(`IMPRC_OFF_PEND, 32'h0);
    rdc(`IMPRC_OFF_CURID, 32'h5);
    wr(`IMPRC_OFF_EOS, $random(seed));
    rdc(`IMPRC_OFF_EVSTAT, 32'h0);
    wr(`IMPRC_OFF_EOS, 32'h0);
    rdc(`IMPRC_OFF_EVSTAT, 32'h4);
    sourceRequest <= 32'h0;
    $display("test 4 done: normal line and service");
    wr(`IMPRC_OFF_SET, 32'h1);
    repeat (2) @(posedge clock);
    chk({30'h0, fastActive, normalActive}, 32'h2);
    rdc(`IMPRC_OFF_CORE, 32'h1);
    rdc(`IMPRC_OFF_FVEC, fastVector);
    repeat (2) @(posedge clock);
    chk({30'h0, fastActive, normalActive}, 32'h0);
    $display("test 5 done: fast line");
    // protection mode: a read leaves pending alone, a write acknowledges
    wr(`IMPRC_OFF_DEBUG, 32'h1);
    wr(`IMPRC_OFF_SET, 32'h20);
    rdc(`IMPRC_OFF_NVEC, candidateVector);
    rdc(`IMPRC_OFF_PEND, 32'h20);
    wr(`IMPRC_OFF_NVEC, 32'h0);
    rdc(`IMPRC_OFF_PEND, 32'h0);
    wr(`IMPRC_OFF_EOS, 32'h0);
    wr(`IMPRC_OFF_DEBUG, 32'h0);
    wr(`IMPRC_OFF_FFEN, 32'h24);
    wr(`IMPRC_OFF_SET, 32'h20);
    repeat (2) @(posedge clock);
    chk({30'h0, fastActive, normalActive}, 32'h2);
    wr(`IMPRC_OFF_FFDIS, 32'h24);
    wr(`IMPRC_OFF_CLEAR, 32'h20);
    rdc(`IMPRC_OFF_FFSTAT, 32'h0);
    $display("test 6 done: protection mode and fast forcing");
    complete_run;
  end
endmodule
`default_nettype wire
